// >>> verilog/aal_top.sv
// Purpose: alarm handling, reset counting and configuration audit log
// Assumes: every input comes from logic on the clk domain
// Notes:   log storage has no reset and stands in for eeprom
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
module aal_top
(
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 power_up,      // one pulse per power-up
    // register port
    input  wire logic [4:0]           reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [31:0]          reg_rdata,
    // keypad
    input  wire logic                 key_enter,
    // measurement side
    input  wire logic [aal_pkg::NUM_SELF-1:0] self_cause,
    input  wire logic [aal_pkg::NUM_SYS-1:0]  sys_cause,
    input  wire logic                 exc_cause,
    input  wire logic signed [15:0]   flow,
    input  wire logic [15:0]          upper_range_value,
    input  wire logic                 stamp_open,
    input  wire logic                 delivery_active,
    input  wire logic                 param_changed,
    input  wire logic                 zero_cal_done,
    input  wire logic [15:0]          medium_temp,
    input  wire logic [15:0]          resonant_freq,
    input  wire logic                 pulse_in_one,
    input  wire logic                 pulse_in_two,
    // outputs
    output logic                      pulse_output_one,
    output logic                      pulse_output_two,
    output logic                      alarm_active,
    output logic                      irq
);
    import aal_pkg::*;

    // ====================================================================
    // registers
    logic [6:0]             ctrl_ff;
    logic signed [7:0]      rev_limit_ff;
    logic                   pw_ok_ff;
    logic [15:0]            alarm_cnt_ff;
    logic [15:0]            reset_cnt_ff;
    logic [15:0]            cal_temp_ff;
    logic [15:0]            cal_freq_ff;
    logic [IRQ_W-1:0]       irq_stat_ff;
    logic [IRQ_W-1:0]       irq_en_ff;
    logic [NUM_SELF-1:0]    self_disp_ff;
    logic [NUM_SYS-1:0]     sys_latch_ff;
    logic                   rev_disp_ff;
    logic                   stamp_disp_ff;
    logic                   any_prev_ff;
    logic [ENTRY_W-1:0]     log_mem_ff [LOG_DEPTH];
    logic [LOG_IDX_W-1:0]   log_wptr_ff;
    logic [LOG_IDX_W-1:0]   log_count_ff;
    logic [LOG_IDX_W-1:0]   log_view_ff;
    logic [31:0]            reg_rdata_ff;
    logic                   pulse_one_ff;
    logic                   pulse_two_ff;

    // decoded strobes
    logic                   wr_ctrl;
    logic                   wr_cmd;
    logic [6:0]             cmd;
    logic                   clr_alarm;
    logic                   clr_log;
    logic                   log_evt;
    logic [ENTRY_W-1:0]     log_entry;
    logic                   rev_cause;
    logic                   any_alarm;
    logic                   ct_mode;
    logic                   sticky;
    logic [NUM_SELF-1:0]    self_eff;
    aal_pulse_type          pulse_mode;

    // circular index step used by writer and viewer
    function automatic logic [LOG_IDX_W-1:0] step(
        input logic [LOG_IDX_W-1:0] idx,
        input logic                 back
    );
        if (back) begin
            step = (idx == '0) ? LOG_IDX_W'(LOG_DEPTH - 1) : idx - 1'b1;
        end else begin
            step = (idx == LOG_IDX_W'(LOG_DEPTH - 1)) ? '0 : idx + 1'b1;
        end
    endfunction

    // ====================================================================
    // decode
    assign wr_ctrl   = reg_wr && (reg_addr == REG_CTRL);
    assign wr_cmd    = reg_wr && (reg_addr == REG_COMMAND);
    assign cmd       = wr_cmd ? reg_wdata[6:0] : 7'h00;
    assign sticky    = ctrl_ff[CTRL_STICKY];
    assign ct_mode   = ctrl_ff[CTRL_CT_MODE];
    assign pulse_mode = aal_pulse_type'(ctrl_ff[CTRL_PULSE_LO +: 2]);
    // clear allowed in custody mode too, no stamp needed
    assign clr_alarm = cmd[CMD_CLR_ALARM] && pw_ok_ff;
    assign clr_log   = cmd[CMD_CLR_LOG] && pw_ok_ff;

    // excitation monitor only counts when sensor test is on
    always_comb begin
        self_eff    = self_cause;
        self_eff[0] = self_cause[0] |
                      (exc_cause & ctrl_ff[CTRL_SENS_TEST]);
    end

    // reverse flow: flow*100 < limit*urv, limit is negative or zero
    assign rev_cause = ctrl_ff[CTRL_REV_EN] &&
        ($signed({flow, 7'h00}) + $signed({flow, 2'b00}) -
         $signed({flow, 5'h00}) <
         $signed(rev_limit_ff) * $signed({1'b0, upper_range_value}));

    // ====================================================================
    // control and limit registers
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_ff      <= CTRL_RESET;
            rev_limit_ff <= REV_LIMIT_RESET;
            irq_en_ff    <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= reg_wdata[6:0];
            end
            if (reg_wr && reg_addr == REG_REV_LIMIT) begin
                rev_limit_ff <= reg_wdata[7:0];
            end
            if (reg_wr && reg_addr == REG_IRQ_EN) begin
                irq_en_ff <= reg_wdata[IRQ_W-1:0];
            end
        end
    end

    // password validation, consumed by one clear
    always_ff @(posedge clk) begin
        if (rst) begin
            pw_ok_ff <= 1'b0;
        end else if (reg_wr && reg_addr == REG_PASSWORD) begin
            pw_ok_ff <= (reg_wdata[15:0] == CUSTOMER_CODE);
        end else if (clr_alarm || clr_log) begin
            pw_ok_ff <= 1'b0;
        end
    end

    // ====================================================================
    // alarm display state
    always_ff @(posedge clk) begin
        if (rst) begin
            self_disp_ff  <= '0;
            rev_disp_ff   <= 1'b0;
            stamp_disp_ff <= 1'b0;
        end else if (clr_alarm || (ct_mode && key_enter)) begin
            // acknowledge: only present causes survive
            self_disp_ff  <= self_eff;
            rev_disp_ff   <= rev_cause;
            stamp_disp_ff <= stamp_open && ctrl_ff[CTRL_CUSTODY_ONLY];
        end else if (sticky || ct_mode) begin
            self_disp_ff  <= self_disp_ff | self_eff;
            rev_disp_ff   <= rev_disp_ff | rev_cause;
            stamp_disp_ff <= stamp_disp_ff |
                             (stamp_open && ctrl_ff[CTRL_CUSTODY_ONLY]);
        end else begin
            self_disp_ff  <= self_eff;
            rev_disp_ff   <= rev_cause;
            stamp_disp_ff <= stamp_open && ctrl_ff[CTRL_CUSTODY_ONLY];
        end
    end

    // system errors latch until manual reset command
    always_ff @(posedge clk) begin
        if (rst) begin
            sys_latch_ff <= '0;
        end else if (cmd[CMD_SYS_RESET]) begin
            sys_latch_ff <= sys_cause;
        end else begin
            sys_latch_ff <= sys_latch_ff | sys_cause;
        end
    end

    assign any_alarm = (|self_disp_ff) | (|sys_latch_ff) |
                       rev_disp_ff | stamp_disp_ff;
    assign alarm_active = any_alarm;

    // ====================================================================
    // alarm level of the previous cycle, for edge counting
    always_ff @(posedge clk) begin
        if (rst) begin
            any_prev_ff <= 1'b0;
        end else begin
            any_prev_ff <= any_alarm;
        end
    end

    // counts cycles with an edge of the alarm level or a power-up
    always_ff @(posedge clk) begin
        if (rst) begin
            alarm_cnt_ff <= '0;
        end else if (power_up || (any_alarm != any_prev_ff)) begin
            alarm_cnt_ff <= alarm_cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            reset_cnt_ff <= '0;
        end else if (clr_alarm) begin
            reset_cnt_ff <= reset_cnt_ff + 1'b1;
        end
    end

    // ====================================================================
    // audit log source, one entry per cycle; clear beats others
    always_comb begin
        log_evt   = 1'b1;
        log_entry = '0;
        if (clr_alarm) begin
            log_entry = {EV_ALARM_RST, reset_cnt_ff[11:0]};
        end else if (ct_mode && any_alarm && !any_prev_ff) begin
            log_entry = {EV_ERROR, 4'h0, 4'(sys_latch_ff),
                         self_disp_ff[3:0]};
        end else if (cmd[CMD_CAL_START]) begin
            log_entry = {EV_CAL, 12'h000};
        end else if (zero_cal_done) begin
            log_entry = {EV_CAL, 12'h001};
        end else if (param_changed || wr_ctrl) begin
            log_entry = {EV_PARAM, 5'h00, ctrl_ff};
        end else if (stamp_open && !stamp_disp_ff &&
                     ctrl_ff[CTRL_CUSTODY_ONLY]) begin
            log_entry = {EV_STAMP, 12'h000};
        end else begin
            log_evt = 1'b0;
        end
    end

    // circular eeprom image of the latest entries
    always_ff @(posedge clk) begin
        if (log_evt && !clr_log) begin
            log_mem_ff[log_wptr_ff] <= log_entry;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || clr_log) begin
            log_wptr_ff  <= '0;
            log_count_ff <= '0;
        end else if (log_evt) begin
            log_wptr_ff <= step(log_wptr_ff, 1'b0);
            if (log_count_ff != LOG_IDX_W'(LOG_DEPTH)) begin
                log_count_ff <= log_count_ff + 1'b1;
            end
        end
    end

    // viewer: open lands on newest entry, then steps either way
    always_ff @(posedge clk) begin
        if (rst) begin
            log_view_ff <= '0;
        end else if (cmd[CMD_LOG_OPEN]) begin
            log_view_ff <= step(log_wptr_ff, 1'b1);
        end else if (cmd[CMD_LOG_NEXT]) begin
            log_view_ff <= step(log_view_ff, 1'b0);
        end else if (cmd[CMD_LOG_PREV]) begin
            log_view_ff <= step(log_view_ff, 1'b1);
        end
    end

    // ====================================================================
    // calibration capture on start
    always_ff @(posedge clk) begin
        if (rst) begin
            cal_temp_ff <= '0;
            cal_freq_ff <= '0;
        end else if (cmd[CMD_CAL_START]) begin
            cal_temp_ff <= medium_temp;
            cal_freq_ff <= resonant_freq;
        end
    end

    // ====================================================================
    // interrupts: set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_stat_ff <= '0;
        end else begin
            irq_stat_ff <= (irq_stat_ff &
                ~((reg_wr && reg_addr == REG_IRQ_CLR) ?
                  reg_wdata[IRQ_W-1:0] : '0)) |
                {wr_cmd && (reg_wdata[CMD_CLR_ALARM] ||
                            reg_wdata[CMD_CLR_LOG]) && !pw_ok_ff,
                 !any_alarm && any_prev_ff,
                 any_alarm && !any_prev_ff};
        end
    end
    assign irq = |(irq_stat_ff & irq_en_ff);

    // ====================================================================
    // pulse gating while an alarm stands in a delivery
    always_ff @(posedge clk) begin
        if (rst) begin
            pulse_one_ff <= 1'b0;
            pulse_two_ff <= 1'b0;
        end else begin
            pulse_one_ff <= pulse_in_one && !(any_alarm &&
                delivery_active && pulse_mode == HALT_BOTH_PULSES);
            pulse_two_ff <= pulse_in_two && !(any_alarm &&
                delivery_active && pulse_mode != PULSE_KEEP);
        end
    end
    assign pulse_output_one = pulse_one_ff;
    assign pulse_output_two = pulse_two_ff;

    // ====================================================================
    // read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata_ff <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_CTRL:      reg_rdata_ff <= {25'h0, ctrl_ff};
                REG_REV_LIMIT: reg_rdata_ff <= {{24{rev_limit_ff[7]}},
                                                rev_limit_ff};
                REG_PASSWORD:  reg_rdata_ff <= {31'h0, pw_ok_ff};
                REG_ALARMS:    reg_rdata_ff <= {18'h0, stamp_disp_ff,
                                   rev_disp_ff, sys_latch_ff,
                                   self_disp_ff};
                REG_ALARM_CNT: reg_rdata_ff <= {16'h0, alarm_cnt_ff};
                REG_RESET_CNT: reg_rdata_ff <= {16'h0, reset_cnt_ff};
                REG_LOG_COUNT: reg_rdata_ff <= {27'h0, log_count_ff};
                REG_LOG_DATA:  reg_rdata_ff <= {16'h0,
                                   log_mem_ff[log_view_ff]};
                REG_LOG_PTR:   reg_rdata_ff <= {27'h0, log_view_ff};
                REG_CAL_TEMP:  reg_rdata_ff <= {16'h0, cal_temp_ff};
                REG_CAL_FREQ:  reg_rdata_ff <= {16'h0, cal_freq_ff};
                REG_IRQ_STAT:  reg_rdata_ff <= {29'h0, irq_stat_ff};
                REG_IRQ_EN:    reg_rdata_ff <= {29'h0, irq_en_ff};
                default:       reg_rdata_ff <= '0;
            endcase
        end else begin
            reg_rdata_ff <= '0;
        end
    end
    assign reg_rdata = reg_rdata_ff;
endmodule

// >>> verilog/aal_pkg.sv
// Purpose: constants for the alarm and audit log manager
// Assumes: 20 MHz clock, synchronous active-high reset
// Notes:   offsets are word addresses
package aal_pkg;
    // ====================================================================
    // sizes
    localparam int          LOG_DEPTH    = 20;
    localparam int          LOG_IDX_W    = 5;
    localparam int          ENTRY_W      = 16;
    localparam int          CNT_W        = 16;
    localparam int          NUM_SELF     = 8;
    localparam int          NUM_SYS      = 4;
    localparam logic [15:0] CUSTOMER_CODE = 16'd5773;

    // ====================================================================
    // register offsets
    localparam logic [4:0] REG_CTRL      = 5'h00;
    localparam logic [4:0] REG_REV_LIMIT = 5'h01;
    localparam logic [4:0] REG_PASSWORD  = 5'h02;
    localparam logic [4:0] REG_COMMAND   = 5'h03;
    localparam logic [4:0] REG_ALARMS    = 5'h04;
    localparam logic [4:0] REG_ALARM_CNT = 5'h05;
    localparam logic [4:0] REG_RESET_CNT = 5'h06;
    localparam logic [4:0] REG_LOG_COUNT = 5'h07;
    localparam logic [4:0] REG_LOG_DATA  = 5'h08;
    localparam logic [4:0] REG_CAL_TEMP  = 5'h09;
    localparam logic [4:0] REG_CAL_FREQ  = 5'h0a;
    localparam logic [4:0] REG_IRQ_STAT  = 5'h0b;
    localparam logic [4:0] REG_IRQ_EN    = 5'h0c;
    localparam logic [4:0] REG_IRQ_CLR   = 5'h0d;
    localparam logic [4:0] REG_LOG_PTR   = 5'h0e;

    // ====================================================================
    // control fields
    localparam int CTRL_STICKY   = 0;
    localparam int CTRL_REV_EN   = 1;
    localparam int CTRL_CUSTODY_ONLY = 2;
    localparam int CTRL_PULSE_LO = 3;
    localparam int CTRL_CT_MODE  = 5;
    localparam int CTRL_SENS_TEST = 6;
    // sticky off, rev off, custody-only on, halt second, sensor test on
    localparam logic [6:0] CTRL_RESET = 7'h4c;

    // command bits
    localparam int CMD_CLR_ALARM = 0;
    localparam int CMD_CLR_LOG   = 1;
    localparam int CMD_CAL_START = 2;
    localparam int CMD_SYS_RESET = 3;
    localparam int CMD_LOG_NEXT  = 4;
    localparam int CMD_LOG_PREV  = 5;
    localparam int CMD_LOG_OPEN  = 6;

    // reverse flow limit, percent of upper range value, signed
    localparam logic signed [7:0] REV_LIMIT_RESET = 8'sh00;

    // audit entry kinds, upper nibble of an entry
    localparam logic [3:0] EV_PARAM    = 4'h1;
    localparam logic [3:0] EV_ALARM_RST = 4'h2;
    localparam logic [3:0] EV_ERROR    = 4'h3;
    localparam logic [3:0] EV_CAL      = 4'h4;
    localparam logic [3:0] EV_STAMP    = 4'h5;

    // interrupt status bits
    localparam int IRQ_ALARM_UP  = 0;
    localparam int IRQ_ALARM_DN  = 1;
    localparam int IRQ_REFUSED   = 2;
    localparam int IRQ_W         = 3;

    // pulse gating modes
    typedef enum logic [1:0] {
        PULSE_KEEP        = 2'h0,
        HALT_SECOND_PULSE = 2'h1,
        HALT_BOTH_PULSES  = 2'h2
    } aal_pulse_type;
endpackage

// >>> dv/aal_top_sva.sv
// Purpose: port checks for aal_top
// Assumes: one clock, rst synchronous active high
// Notes:   shadows the control word from register writes
module aal_top_sva
    import aal_pkg::*;
(
    // clock and reset
    input wire logic                        clk,
    input wire logic                        rst,
    // register port
    input wire logic [4:0]                  reg_addr,
    input wire logic [31:0]                 reg_wdata,
    input wire logic                        reg_wr,
    input wire logic                        reg_rd,
    input wire logic [31:0]                 reg_rdata,
    // measurement side and outputs
    input wire logic [aal_pkg::NUM_SYS-1:0] sys_cause,
    input wire logic                        delivery_active,
    input wire logic                        pulse_in_one,
    input wire logic                        pulse_in_two,
    input wire logic                        pulse_output_one,
    input wire logic                        pulse_output_two,
    input wire logic                        alarm_active
);
    logic [6:0] ctrl_ff;
    logic       gate;
    // ====================================================================
    // control shadow; default halts only the second output
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_ff <= 7'h4c;
        end else if (reg_wr && reg_addr == REG_CTRL) begin
            ctrl_ff <= reg_wdata[6:0];
        end
    end
    assign gate = alarm_active && delivery_active;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data not zero outside a read");
    a_unmapped_zero: assert property (
        reg_rd && reg_addr > REG_LOG_PTR |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_ctrl_value: assert property (
        reg_rd && reg_addr == REG_CTRL
        |=> reg_rdata == {25'h0, $past(ctrl_ff)})
        else $error("control read wrong");
    a_one_follows: assert property (
        ctrl_ff[4:3] != 2'h2
        |=> pulse_output_one == $past(pulse_in_one))
        else $error("first output not following its input");
    a_two_follows: assert property (
        (ctrl_ff[4:3] == 2'h0 || !gate)
        |=> pulse_output_two == $past(pulse_in_two))
        else $error("second output not following its input");
    a_two_halted: assert property (
        ctrl_ff[4:3] != 2'h0 && gate |=> !pulse_output_two)
        else $error("second output pulsed during alarm");
    a_both_halted: assert property (
        ctrl_ff[4:3] == 2'h2 && gate |=> !pulse_output_one)
        else $error("first output pulsed during alarm");
    a_sys_raise: assert property (
        $rose(sys_cause[0]) |-> ##[0:2] alarm_active)
        else $error("system error gave no alarm");
    a_sys_latch: assert property (
        $fell(sys_cause[0]) && alarm_active |=> alarm_active [*4])
        else $error("system error alarm not held");
endmodule

bind aal_top aal_top_sva u_sva (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sys_cause(sys_cause), .delivery_active(delivery_active),
    .pulse_in_one(pulse_in_one), .pulse_in_two(pulse_in_two),
    .pulse_output_one(pulse_output_one), .pulse_output_two(pulse_output_two),
    .alarm_active(alarm_active)
);

// >>> dv/aal_keypad_model.sv
// Purpose: keypad of the operator unit, sends enter presses
// Assumes: press requests come from the bench after a clock edge
// Notes:   a press is one clock long, like a debounced key
module aal_keypad_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // request and key line
    input  wire logic press,
    output logic      key_enter
);
    timeunit 1ns;
    timeprecision 1ns;
    // ====================================================================
    // one pulse per request, repeated every second cycle while held
    always_ff @(posedge clk) begin
        if (rst) begin
            key_enter <= 1'b0;
        end else begin
            key_enter <= press && !key_enter;
        end
    end
endmodule

// >>> dv/tb_alarm_and_audit_log_manager.sv
// Purpose: self-checking bench for aal_top
// Assumes: 50 ns clock, reset held two cycles
// Notes:   random pulses and values from an xorshift seeded at 96
module tb_alarm_and_audit_log_manager;
    timeunit 1ns;
    timeprecision 1ns;
    import aal_pkg::*;
    logic                clk, rst, power_up, reg_wr, reg_rd, key_press;
    logic                key_enter, exc_cause, stamp_open, delivery_active;
    logic                param_changed, zero_cal_done, irq, alarm_active;
    logic                pulse_in_one, pulse_in_two, pls_one, pls_two;
    logic [4:0]          reg_addr;
    logic [31:0]         reg_wdata, reg_rdata, base, r;
    logic [NUM_SELF-1:0] self_cause;
    logic [NUM_SYS-1:0]  sys_cause;
    logic signed [15:0]  flow;
    logic [15:0]         upper_range_value, medium_temp, resonant_freq;
    logic [31:0]         seed = 32'h60;
    int                  num_errors = 0;
    int                  tests_run = 0;
    aal_top DUT (.clk(clk), .rst(rst), .power_up(power_up),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .key_enter(key_enter),
        .self_cause(self_cause), .sys_cause(sys_cause),
        .exc_cause(exc_cause), .flow(flow),
        .upper_range_value(upper_range_value), .stamp_open(stamp_open),
        .delivery_active(delivery_active), .param_changed(param_changed),
        .zero_cal_done(zero_cal_done), .medium_temp(medium_temp),
        .resonant_freq(resonant_freq), .pulse_in_one(pulse_in_one),
        .pulse_in_two(pulse_in_two), .pulse_output_one(pls_one),
        .pulse_output_two(pls_two), .alarm_active(alarm_active), .irq(irq));
    aal_keypad_model u_keys (.clk(clk), .rst(rst), .press(key_press),
        .key_enter(key_enter));
    // ====================================================================
    // helpers: random source, bus cycles, compares
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic pw();
        wr(REG_PASSWORD, {16'h0, CUSTOMER_CODE});
    endtask
    task automatic chk_word(input string n, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_bit(input string n, input logic e, g);
        chk_word(n, {31'h0, e}, {31'h0, g});
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rdc(input logic [4:0] a, input logic [31:0] m, e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        base = reg_rdata;
        chk_word($sformatf("reg %h", a), e, base & m);
    endtask
    task automatic alarm_is(input logic e);
        cyc(3);
        chk_bit("alarm_active", e, alarm_active);
    endtask
    task automatic blip();
        self_cause <= 8'h02;
        cyc(3);
        self_cause <= 8'h00;
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ====================================================================
    // clock and watchdog; a hang is a mismatch
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        end_sim();
    end
    // main sequence
    initial begin
        {rst, power_up, reg_wr, reg_rd, key_press, exc_cause} = 6'h20;
        {stamp_open, delivery_active, param_changed, zero_cal_done} = 4'h0;
        {pulse_in_one, pulse_in_two, reg_addr, reg_wdata, flow} = '0;
        {self_cause, sys_cause, medium_temp, resonant_freq} = '0;
        upper_range_value = 16'h03e8;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc(REG_CTRL, '1, 32'h4c);
        rdc(REG_REV_LIMIT, 32'hff, 32'h0);
        rdc(5'h1f, '1, 32'h0);
        rdc(REG_RESET_CNT, 32'hffff, 32'h0);
        r = base;
        wr(REG_COMMAND, 32'h1);
        wr(REG_COMMAND, 32'h2);
        rdc(REG_IRQ_STAT, 32'h4, 32'h4);
        wr(REG_IRQ_EN, 32'h4);
        cyc(1);
        chk_bit("irq", 1'b1, irq);
        wr(REG_IRQ_CLR, 32'h4);
        cyc(1);
        chk_bit("irq", 1'b0, irq);
        rdc(REG_RESET_CNT, 32'hffff, r);
        wr(REG_CTRL, 32'h6c);
        pw();
        rdc(REG_PASSWORD, 32'h1, 32'h1);
        wr(REG_COMMAND, 32'h1);
        rdc(REG_RESET_CNT, 32'hffff, r + 32'h1);
        wr(REG_COMMAND, 32'h40);
        rdc(REG_LOG_DATA, 32'hf000, 32'h2000);
        wr(REG_COMMAND, 32'h1);
        rdc(REG_RESET_CNT, 32'hffff, r + 32'h1);
        blip();
        alarm_is(1'b1);
        key_press <= 1'b1;
        cyc(1);
        key_press <= 1'b0;
        alarm_is(1'b0);
        wr(REG_COMMAND, 32'h40);
        rdc(REG_LOG_DATA, 32'hf000, 32'h3000);
        wr(REG_CTRL, 32'h4c);
        rdc(REG_ALARM_CNT, 32'hffff, 32'h2);
        r = base;
        blip();
        alarm_is(1'b0);
        rdc(REG_ALARM_CNT, 32'hffff, r + 32'h2);
        power_up <= 1'b1;
        cyc(1);
        power_up <= 1'b0;
        rdc(REG_ALARM_CNT, 32'hffff, r + 32'h3);
        exc_cause <= 1'b1;
        alarm_is(1'b1);
        wr(REG_CTRL, 32'h0c);
        alarm_is(1'b0);
        exc_cause <= 1'b0;
        wr(REG_CTRL, 32'h4d);
        blip();
        alarm_is(1'b1);
        pw();
        wr(REG_COMMAND, 32'h1);
        alarm_is(1'b0);
        // reverse flow: limit zero, then ten percent of range
        wr(REG_CTRL, 32'h4c);
        flow <= -16'sd5;
        alarm_is(1'b0);
        wr(REG_CTRL, 32'h4e);
        alarm_is(1'b1);
        wr(REG_REV_LIMIT, 32'hf6);
        flow <= -16'sd50;
        alarm_is(1'b0);
        flow <= -16'sd150;
        alarm_is(1'b1);
        flow <= 16'sd0;
        wr(REG_CTRL, 32'h4c);
        stamp_open <= 1'b1;
        alarm_is(1'b1);
        stamp_open <= 1'b0;
        sys_cause <= 4'h1;
        cyc(2);
        sys_cause <= 4'h0;
        alarm_is(1'b1);
        // pulse gating, every mode, random pulses and deliveries
        for (int m = 0; m < 3; m++) begin
            wr(REG_CTRL, 32'h44 | (m << 3));
            repeat (40) begin
                @(posedge clk);
                r = rnd();
                pulse_in_one    <= r[0];
                pulse_in_two    <= r[1];
                delivery_active <= r[2] | r[3];
            end
        end
        delivery_active <= 1'b0;
        wr(REG_CTRL, 32'h4c);
        wr(REG_COMMAND, 32'h8);
        pw();
        wr(REG_COMMAND, 32'h1);
        alarm_is(1'b0);
        // audit log: overfill, calibration, then step through
        for (int i = 0; i < 22; i++) begin
            param_changed <= i[0] || i == 21;
            zero_cal_done <= !i[0] && i != 21;
            cyc(1);
            {param_changed, zero_cal_done} <= 2'h0;
            cyc(1);
        end
        rdc(REG_LOG_COUNT, 32'hff, 32'h14);
        r = rnd();
        medium_temp   <= r[15:0];
        resonant_freq <= r[31:16];
        wr(REG_COMMAND, 32'h4);
        rdc(REG_CAL_TEMP, 32'hffff, {16'h0, r[15:0]});
        rdc(REG_CAL_FREQ, 32'hffff, {16'h0, r[31:16]});
        wr(REG_COMMAND, 32'h40);
        rdc(REG_LOG_DATA, 32'hf000, 32'h4000);
        wr(REG_COMMAND, 32'h20);
        rdc(REG_LOG_DATA, 32'hf000, 32'h1000);
        wr(REG_COMMAND, 32'h10);
        rdc(REG_LOG_DATA, 32'hf000, 32'h4000);
        end_sim();
    end
endmodule
